// [rtl/swr_regbank.sv]
// Functional notes
// R1: Regulators run only while the clock generator supplies their 24 MHz clock; here only stepdown_en is gated by it, boost and audio bytes are not.
// R2: No regulator turns on unless the global enable is set; here only stepdown_en is gated by it, boost and audio bytes are not.
// R3: Software sets voltage and current limit before a regulator's enable bit.
// R4: Each register is one 8-bit word per address.
// R5: Step-down pairs sit at 0xA080, 0xA082 and 0xA084.
// R6: Backlight boost pair sits at 0xA086.
// R7: Five volt boost pair sits at 0xA088.
// R8: Audio bridge block is four bytes at 0xA08A.
// R9: Output voltage steps by 25 mV from 0.75 V to 3.70 V.
// R10: Output voltage reset code is a fixed mask value per converter.
// R11: Current limit selects 25, 50, 75 or 100 percent of full scale.
// R12: Control bits [3:2] both one select full-scale current limit.
// R13: Each step-down converter selects PWM or pulse frequency mode.
// R14: PWM switching clock selects 1 MHz or 2 MHz.
// R15: The three step-down converters share one layout and behaviour.
// R16: Host controls converter start-up order through the registers.
// R17: Voltage register bits [6:0] hold the code, bit 7 the enable.
// R18: Voltage register at even address, control register at next odd address.
// R19: Clearing global enable forces all outputs off, keeping settings; here only stepdown_en is forced off, boost and audio bytes stay.
`timescale 1ns/1ps
`default_nettype none

module swr_regbank
  import swr_pkg::*;
(
  // Clock and reset.
  input  wire logic                   clk,
  input  wire logic                   srst,
  // Register port.
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  input  wire logic [ADDR_W-1:0]      reg_addr,
  input  wire logic [DATA_W-1:0]      reg_wdata,
  output logic      [DATA_W-1:0]      reg_rdata,
  output logic                        reg_rvalid,
  // Clock generator status.
  input  wire logic                   clock_generator_ready,
  // Step-down converter controls.
  output logic      [2:0]             stepdown_en,
  output logic      [2:0][6:0]        stepdown_vout,
  output logic      [2:0][1:0]        stepdown_ilimit,
  output logic      [2:0]             stepdown_pfm,
  output logic      [2:0]             stepdown_fast_clk,
  // Global state and other regulator bytes.
  output logic                        switcher_global_enable,
  output logic      [15:0]            backlight_boost_ctrl,
  output logic      [15:0]            five_volt_boost_ctrl,
  output logic      [31:0]            audio_bridge_ctrl
);

  localparam logic [2:0][6:0] SD_RESET = {VOUT_RESET_HC, VOUT_RESET_B, VOUT_RESET_A};
  localparam logic [2:0][15:0] SD_BASE = {ADDR_STEPDOWN_HC, ADDR_STEPDOWN_B,
                                          ADDR_STEPDOWN_A};

  // True when addr lies in [base, base + len).
  function automatic logic in_range(input logic [15:0] addr,
                                    input logic [15:0] base,
                                    input int          len);
    logic [16:0] top;
    top      = {1'b0, base} + 17'(len);
    in_range = ({1'b0, addr} >= {1'b0, base}) && ({1'b0, addr} < top);
  endfunction

  // Byte index within a block starting at base.
  function automatic logic [2:0] byte_index(input logic [15:0] addr,
                                            input logic [15:0] base);
    logic [15:0] diff;
    diff       = addr - base;
    byte_index = diff[2:0];
  endfunction

  // Address decode.
  wire        hit_global;
  wire [2:0]  hit_sd_vout;
  wire [2:0]  hit_sd_ctrl;
  wire        hit_aux;
  wire        hit_spare;
  wire [2:0]  aux_idx;
  wire        allow_on;

  assign hit_global = (reg_addr == ADDR_GLOBAL_ENABLE);
  assign hit_aux    = in_range(reg_addr, ADDR_BACKLIGHT_BOOST, AUX_BYTES); // R6 R7 R8
  assign hit_spare  = in_range(reg_addr, ADDR_SPARE, PAIR_BYTES);
  assign aux_idx    = byte_index(reg_addr, ADDR_BACKLIGHT_BOOST);

  genvar g;
  generate
    for (g = 0; g < STEPDOWN_COUNT; g++)
    begin : g_dec
      assign hit_sd_vout[g] = (reg_addr == SD_BASE[g]); // R5 R18
      assign hit_sd_ctrl[g] = (reg_addr == (SD_BASE[g] + 16'h0001)); // R18
    end
  endgenerate

  // Global enable register.
  logic global_en;

  always_ff @(posedge clk)
  begin
    if (srst)
      global_en <= GLOBAL_RESET;
    else if (reg_wr && hit_global)
      global_en <= reg_wdata[GLOBAL_ENABLE_BIT]; // R2
  end

  assign switcher_global_enable = global_en;

  // A step-down converter may only run with the global enable set and its clock present.
  assign allow_on = global_en & clock_generator_ready; // R1 R2 R19

  // Step-down converters, one instance each, alike but for the reset voltage code.
  logic [2:0][7:0] sd_vout_reg;
  logic [2:0][7:0] sd_ctrl_reg;

  generate
    for (g = 0; g < STEPDOWN_COUNT; g++)
    begin : g_sd
      swr_ilim_t ilim;

      swr_stepdown #(
        .RESET_VOUT (SD_RESET[g]) // R10
      ) u_sd (  // R15
        .clk      (clk),
        .srst     (srst),
        .wr_vout  (reg_wr && hit_sd_vout[g]),
        .wr_ctrl  (reg_wr && hit_sd_ctrl[g]),
        .wdata    (reg_wdata),
        .allow_on (allow_on),
        .vout_reg (sd_vout_reg[g]),
        .ctrl_reg (sd_ctrl_reg[g]),
        .out_en   (stepdown_en[g]),
        .vout_code(stepdown_vout[g]),
        .ilimit   (ilim),
        .pfm_mode (stepdown_pfm[g]),
        .fast_clk (stepdown_fast_clk[g])
      );

      assign stepdown_ilimit[g] = ilim;
    end
  endgenerate

  // Boost and audio bytes are held as plain control words.
  logic [7:0] aux_mem [AUX_BYTES];

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      for (int i = 0; i < AUX_BYTES; i++)
        aux_mem[i] <= AUX_RESET;
    end
    else if (reg_wr && hit_aux)
      aux_mem[aux_idx] <= reg_wdata; // R4
  end

  assign backlight_boost_ctrl = {aux_mem[1], aux_mem[0]};
  assign five_volt_boost_ctrl = {aux_mem[3], aux_mem[2]};
  assign audio_bridge_ctrl    = {aux_mem[7], aux_mem[6], aux_mem[5], aux_mem[4]};

  // Read selection. Spare and unmapped addresses read as zero.
  logic [7:0] read_sel;

  always_comb
  begin
    read_sel = 8'h00;
    if (hit_global)
      read_sel = {7'h00, global_en};
    else if (hit_aux)
      read_sel = aux_mem[aux_idx];
    for (int i = 0; i < STEPDOWN_COUNT; i++)
    begin
      if (hit_sd_vout[i])
        read_sel = sd_vout_reg[i];
      if (hit_sd_ctrl[i])
        read_sel = sd_ctrl_reg[i];
    end
  end

  logic [7:0] next_rdata;

  assign next_rdata = reg_rd ? read_sel : reg_rdata;

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      reg_rdata  <= 8'h00;
      reg_rvalid <= 1'b0;
    end
    else
    begin
      reg_rdata  <= next_rdata; // R4
      reg_rvalid <= reg_rd;
    end
  end

  // Checks.
  a_global_gate: assert property (@(posedge clk) disable iff (srst) // R2
    !allow_on |=> stepdown_en == 3'b000)
    else $error("Converter on without global enable");

  a_global_hold: assert property (@(posedge clk) disable iff (srst) // R19
    reg_wr && hit_global && !reg_wdata[0] ##1 !reg_wr [*2]
      |-> $stable(stepdown_vout))
    else $error("Settings lost when global enable cleared");

  a_clock_gate: assert property (@(posedge clk) disable iff (srst) // R1
    !clock_generator_ready |=> stepdown_en == 3'b000)
    else $error("Converter on without clock generator");

  a_read_latency: assert property (@(posedge clk) disable iff (srst) // R4
    reg_rd |=> reg_rvalid ##1 ($past(reg_rd) || !reg_rvalid))
    else $error("Read answer not one cycle after request");

  a_rvalid_idle: assert property (@(posedge clk) disable iff (srst) // R4
    !reg_rd |=> !reg_rvalid)
    else $error("Read answer without a read request");

  a_rdata_hold: assert property (@(posedge clk) disable iff (srst) // R4
    !reg_rd |=> $stable(reg_rdata))
    else $error("Read data changed without a read request");

  a_global_reserved: assert property (@(posedge clk) disable iff (srst) // R4
    reg_rd && hit_global |=> reg_rdata[7:1] == 7'h00)
    else $error("Global enable reserved bits read non-zero");

  a_ctrl_reserved: assert property (@(posedge clk) disable iff (srst) // R12
    reg_rd && (|hit_sd_ctrl) |=> reg_rdata[7:4] == 4'h0)
    else $error("Control register reserved bits read non-zero");

  a_global_store: assert property (@(posedge clk) disable iff (srst) // R2
    reg_wr && hit_global |=> switcher_global_enable == $past(reg_wdata[0]))
    else $error("Global enable write not stored");

  a_global_reset: assert property (@(posedge clk) // R2
    srst |=> !switcher_global_enable && stepdown_en == 3'b000 && !reg_rvalid)
    else $error("Global state not cleared by reset");

  a_enable_follow: assert property (@(posedge clk) disable iff (srst) // R2 R19
    1'b1 |=> stepdown_en == ($past(allow_on)
      ? {$past(sd_vout_reg[2][7]), $past(sd_vout_reg[1][7]), $past(sd_vout_reg[0][7])}
      : 3'b000))
    else $error("Converter enable does not follow its gate");

  a_hc_ilimit: assert property (@(posedge clk) disable iff (srst) // R11 R15
    reg_wr && hit_sd_ctrl[2] |=> stepdown_ilimit[2] == $past(reg_wdata[3:2]))
    else $error("High current limit write not applied");

  a_pfm_write: assert property (@(posedge clk) disable iff (srst) // R13
    reg_wr && hit_sd_ctrl[0] |=> stepdown_pfm[0] == $past(reg_wdata[0]))
    else $error("Step-down A mode select not applied");

  a_fast_write: assert property (@(posedge clk) disable iff (srst) // R14
    reg_wr && hit_sd_ctrl[1] |=> stepdown_fast_clk[1] == $past(reg_wdata[1]))
    else $error("Step-down B clock select not applied");

  a_sd_vout_store: assert property (@(posedge clk) disable iff (srst) // R9 R17
    reg_wr && hit_sd_vout[1] |=> stepdown_vout[1] == $past(reg_wdata[6:0]))
    else $error("Step-down B voltage code not applied");

  a_hc_vout_store: assert property (@(posedge clk) disable iff (srst) // R15 R17
    reg_wr && hit_sd_vout[2] |=> stepdown_vout[2] == $past(reg_wdata[6:0]))
    else $error("High current voltage code not applied");

  a_sd_isolated: assert property (@(posedge clk) disable iff (srst) // R5
    reg_wr && !(|hit_sd_vout) |=> $stable(stepdown_vout))
    else $error("Voltage code changed by another address");

  a_aux_isolated: assert property (@(posedge clk) disable iff (srst) // R4
    reg_wr && !hit_aux |=> $stable(backlight_boost_ctrl)
      && $stable(five_volt_boost_ctrl) && $stable(audio_bridge_ctrl))
    else $error("Boost or audio byte changed by another address");

  a_backlight_low: assert property (@(posedge clk) disable iff (srst) // R6
    reg_wr && reg_addr == 16'hA086 |=> backlight_boost_ctrl[7:0] == $past(reg_wdata))
    else $error("Backlight boost low byte not stored");

  a_unmapped_zero: assert property (@(posedge clk) disable iff (srst)
    reg_rd && (hit_spare || reg_addr == 16'hA090) |=> reg_rdata == 8'h00)
    else $error("Spare or unmapped address read non-zero");

  a_vout_readback: assert property (@(posedge clk) disable iff (srst) // R5 R17
    reg_wr && reg_addr == 16'hA082 ##1 !reg_wr
      ##1 reg_rd && reg_addr == 16'hA082 && !reg_wr
      |=> reg_rdata == $past(reg_wdata, 3))
    else $error("Step-down B voltage read-back mismatch");

  a_ctrl_readback: assert property (@(posedge clk) disable iff (srst) // R18
    reg_wr && reg_addr == 16'hA081 ##1 !reg_wr
      ##1 reg_rd && reg_addr == 16'hA081 && !reg_wr
      |=> reg_rdata == {4'h0, $past(reg_wdata[3:0], 3)})
    else $error("Step-down A control read-back mismatch");

  a_turn_on: assert property (@(posedge clk) disable iff (srst) // R16
    allow_on && reg_wr && reg_addr == 16'hA080 && reg_wdata[7]
      ##1 allow_on |=> stepdown_en[0])
    else $error("Step-down A did not start when enabled");

  a_audio_byte: assert property (@(posedge clk) disable iff (srst) // R8
    reg_wr && reg_addr == 16'hA08D |=> audio_bridge_ctrl[31:24] == $past(reg_wdata))
    else $error("Audio bridge top byte not stored");

  a_boost_byte: assert property (@(posedge clk) disable iff (srst) // R7
    reg_wr && reg_addr == 16'hA088 |=> five_volt_boost_ctrl[7:0] == $past(reg_wdata))
    else $error("Five volt boost byte not stored");

  a_backlight_byte: assert property (@(posedge clk) disable iff (srst) // R6
    reg_wr && reg_addr == 16'hA087 |=> backlight_boost_ctrl[15:8] == $past(reg_wdata))
    else $error("Backlight boost byte not stored");

endmodule // swr_regbank

`default_nettype wire

// [rtl/swr_pkg.sv]
`default_nettype none

package swr_pkg;

  // Register port geometry.
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;

  // Local addresses of the regulator bank.
  localparam logic [15:0] ADDR_GLOBAL_ENABLE   = 16'hA005;
  localparam logic [15:0] ADDR_STEPDOWN_A      = 16'hA080;
  localparam logic [15:0] ADDR_STEPDOWN_B      = 16'hA082;
  localparam logic [15:0] ADDR_STEPDOWN_HC     = 16'hA084;
  localparam logic [15:0] ADDR_BACKLIGHT_BOOST = 16'hA086;
  localparam logic [15:0] ADDR_FIVE_VOLT_BOOST = 16'hA088;
  localparam logic [15:0] ADDR_AUDIO_BRIDGE    = 16'hA08A;
  localparam logic [15:0] ADDR_SPARE           = 16'hA08E;

  // Step-down converter count and sizes of the register groups in bytes.
  localparam int STEPDOWN_COUNT      = 3;
  localparam int PAIR_BYTES          = 2;
  localparam int AUDIO_BYTES         = 4;
  localparam int AUX_BYTES           = 8;

  // Output-voltage register fields.
  localparam int VOUT_CODE_MSB       = 6;
  localparam int VOUT_CODE_LSB       = 0;
  localparam int VOUT_ENABLE_BIT     = 7;
  localparam int VOUT_STEP_MV        = 25;
  localparam int VOUT_BASE_MV        = 750;
  localparam int VOUT_MAX_MV         = 3700;
  localparam logic [6:0] VOUT_MAX_CODE =
    7'((VOUT_MAX_MV - VOUT_BASE_MV) / VOUT_STEP_MV);

  // Control register fields and the global enable bit.
  localparam int CTRL_PFM_BIT        = 0;
  localparam int CTRL_FAST_CLK_BIT   = 1;
  localparam int CTRL_ILIM_MSB       = 3;
  localparam int CTRL_ILIM_LSB       = 2;
  localparam int CTRL_USED_W         = 4;
  localparam int GLOBAL_ENABLE_BIT   = 0;

  // Reset values. Output-voltage codes are mask values per converter.
  localparam logic [6:0] VOUT_RESET_A  = 7'h66;
  localparam logic [6:0] VOUT_RESET_B  = 7'h2A;
  localparam logic [6:0] VOUT_RESET_HC = 7'h12;
  localparam logic [3:0] CTRL_RESET    = 4'hC;
  localparam logic       GLOBAL_RESET  = 1'b0;
  localparam logic [7:0] AUX_RESET     = 8'h00;

  // Current-limit steps as fractions of full scale.
  typedef enum logic [1:0] {
    SWR_ILIM_25  = 2'b00,
    SWR_ILIM_50  = 2'b01,
    SWR_ILIM_75  = 2'b10,
    SWR_ILIM_100 = 2'b11
  } swr_ilim_t;

  // Switching clock figures.
  localparam int REG_CLK_MHZ         = 24;
  localparam int PWM_SLOW_MHZ        = 1;
  localparam int PWM_FAST_MHZ        = 2;

endpackage

`default_nettype wire

// [rtl/swr_stepdown.sv]
`timescale 1ns/1ps
`default_nettype none

module swr_stepdown
  import swr_pkg::*;
#(
  parameter logic [6:0] RESET_VOUT = VOUT_RESET_A
)
(
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       srst,
  // Byte writes from the bank.
  input  wire logic       wr_vout,
  input  wire logic       wr_ctrl,
  input  wire logic [7:0] wdata,
  // Gate from global enable and clock generator.
  input  wire logic       allow_on,
  // Register read-back.
  output logic      [7:0] vout_reg,
  output logic      [7:0] ctrl_reg,
  // Converter controls.
  output logic            out_en,
  output logic      [6:0] vout_code,
  output var swr_ilim_t   ilimit,
  output logic            pfm_mode,
  output logic            fast_clk
);

  logic       en_bit;
  logic [3:0] ctrl;
  logic       next_out_en;

  assign next_out_en = en_bit & allow_on; // R2 R19
  assign vout_reg    = {en_bit, vout_code};
  assign ctrl_reg    = {4'h0, ctrl};
  assign ilimit      = swr_ilim_t'(ctrl[CTRL_ILIM_MSB:CTRL_ILIM_LSB]); // R11 R12
  assign pfm_mode    = ctrl[CTRL_PFM_BIT]; // R13
  assign fast_clk    = ctrl[CTRL_FAST_CLK_BIT]; // R14

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      vout_code <= RESET_VOUT; // R10
      en_bit    <= 1'b0;
    end
    else if (wr_vout)
    begin
      vout_code <= wdata[VOUT_CODE_MSB:VOUT_CODE_LSB]; // R9 R17
      en_bit    <= wdata[VOUT_ENABLE_BIT]; // R16 R17
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      ctrl <= CTRL_RESET;
    else if (wr_ctrl)
      ctrl <= wdata[CTRL_USED_W-1:0]; // R12
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      out_en <= 1'b0;
    else
      out_en <= next_out_en; // R19
  end

  a_vout_write: assert property (@(posedge clk) disable iff (srst) // R17
    wr_vout |=> vout_code == $past(wdata[6:0])
      && en_bit == $past(wdata[7]))
    else $error("Voltage register write not stored");

  a_ilim_full: assert property (@(posedge clk) disable iff (srst) // R12
    wr_ctrl && wdata[3:2] == 2'b11 |=> ilimit == SWR_ILIM_100)
    else $error("Full scale current limit not selected");

  a_reset_vout: assert property (@(posedge clk) // R10
    srst |=> vout_code == RESET_VOUT && !en_bit && !out_en)
    else $error("Voltage code not at mask value after reset");

endmodule // swr_stepdown

`default_nettype wire

// [testbench/swr_host_model.sv]
`timescale 1ns/1ps
`default_nettype none

module swr_host_model
  import swr_pkg::*;
(
  // Clock.
  input  wire logic              clk,
  // Register port.
  output logic                   reg_wr,
  output logic                   reg_rd,
  output logic [ADDR_W-1:0]      reg_addr,
  output logic [DATA_W-1:0]      reg_wdata,
  input  wire logic [DATA_W-1:0] reg_rdata,
  input  wire logic              reg_rvalid
);
  initial
  begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 16'h0000;
    reg_wdata = 8'h00;
  end

  // Idle address and data are inverted so stale values never look valid.
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask

  task automatic rd(input logic [15:0] a, output logic [7:0] d, output logic v);
    @(negedge clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clk);
    reg_rd = 1'b0;
    reg_addr = ~a;
    v = reg_rvalid;
    d = reg_rdata;
  endtask
endmodule // swr_host_model

`default_nettype wire

// [testbench/swr_regbank_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none

module swr_regbank_tb_top;
  import swr_pkg::*;
  logic              clk;
  logic              srst;
  logic              cg_ready;
  logic              reg_wr;
  logic              reg_rd;
  logic [15:0]       reg_addr;
  logic [7:0]        reg_wdata;
  logic [7:0]        reg_rdata;
  logic              reg_rvalid;
  logic [2:0]        en;
  logic [2:0][6:0]   vout;
  logic [2:0][1:0]   ilim;
  logic [2:0]        pulse_frequency_mode;
  logic [2:0]        fast;
  logic              gen;
  logic [15:0]       bl;
  logic [15:0]       fv;
  logic [31:0]       au;
  int                n_mismatch = 0;
  int                compares = 0;
  logic [15:0]       base [3] = '{ADDR_STEPDOWN_A, ADDR_STEPDOWN_B, ADDR_STEPDOWN_HC};
  logic [6:0]        rval [3] = '{VOUT_RESET_A, VOUT_RESET_B, VOUT_RESET_HC};

  swr_host_model host (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

  swr_regbank dut (.clk(clk), .srst(srst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .clock_generator_ready(cg_ready), .stepdown_en(en),
    .stepdown_vout(vout), .stepdown_ilimit(ilim), .stepdown_pfm(pulse_frequency_mode),
    .stepdown_fast_clk(fast), .switcher_global_enable(gen), .backlight_boost_ctrl(bl),
    .five_volt_boost_ctrl(fv), .audio_bridge_ctrl(au));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
      n_mismatch++;
    end
  endtask

  task automatic rchk(input logic [15:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic       v;
    host.rd(a, d, v);
    chk("rvalid", 32'h1, {31'h0, v});
    chk($sformatf("read %h", a), {24'h0, e}, {24'h0, d});
  endtask

  // The gated enable lands one cycle after the register bit.
  task automatic settle();
    repeat (2) @(negedge clk);
  endtask

  task automatic t_reset();
    for (int i = 0; i < 3; i++)
    begin
      rchk(base[i], {1'b0, rval[i]});
      rchk(base[i] + 16'h1, {4'h0, CTRL_RESET});
      chk("ilimit", 32'h3, {30'h0, ilim[i]});
    end
    rchk(ADDR_GLOBAL_ENABLE, 8'h00);
    chk("global", 32'h0, {31'h0, gen});
    chk("en", 32'h0, {29'h0, en});
    chk("backlight reset", 32'h0, {16'h0, bl});
    chk("five_volt reset", 32'h0, {16'h0, fv});
    chk("audio reset", 32'h0, au);
    $display("test reset done");
  endtask

  task automatic t_map();
    for (int a = 0; a < 8; a++)
      host.wr(16'hA086 + 16'(a), 8'hA1 + 8'(a));
    for (int a = 0; a < 8; a++)
      rchk(16'hA086 + 16'(a), 8'hA1 + 8'(a));
    chk("backlight", 32'hA2A1, {16'h0, bl});
    chk("five_volt", 32'hA4A3, {16'h0, fv});
    chk("audio", 32'hA8A7A6A5, au);
    host.wr(ADDR_SPARE, 8'hFF);
    rchk(ADDR_SPARE, 8'h00);
    rchk(16'hA010, 8'h00);
    host.wr(16'hA081, 8'hFF);
    rchk(16'hA081, 8'h0F);
    host.wr(ADDR_GLOBAL_ENABLE, 8'hFE);
    rchk(ADDR_GLOBAL_ENABLE, 8'h00);
    $display("test map done");
  endtask

  task automatic t_fields();
    for (int i = 0; i < 3; i++)
    begin
      for (int c = 0; c < 16; c++)
      begin
        host.wr(base[i] + 16'h1, 8'(c));
        chk("ilimit", 32'(c >> 2), {30'h0, ilim[i]});
        chk("pfm", 32'(c & 1), {31'h0, pulse_frequency_mode[i]});
        chk("fast", 32'((c >> 1) & 1), {31'h0, fast[i]});
      end
      host.wr(base[i], {1'b0, VOUT_MAX_CODE});
      chk("vout", 32'(VOUT_MAX_CODE), {25'h0, vout[i]});
      rchk(base[i], {1'b0, VOUT_MAX_CODE});
    end
    $display("test fields done");
  endtask

  task automatic t_enable();
    for (int i = 0; i < 3; i++)
    begin
      host.wr(base[i] + 16'h1, 8'h0C);
      host.wr(base[i], 8'hA0);
      settle();
      chk("en gated", 32'h0, {29'h0, en});
      host.wr(ADDR_GLOBAL_ENABLE, 8'h01);
      chk("global on", 32'h1, {31'h0, gen});
      settle();
      chk("en on", 32'(1 << i), {29'h0, en});
      cg_ready = 1'b0;
      settle();
      chk("en no clock", 32'h0, {29'h0, en});
      cg_ready = 1'b1;
      settle();
      chk("en clock back", 32'(1 << i), {29'h0, en});
      host.wr(ADDR_GLOBAL_ENABLE, 8'h00);
      chk("global off", 32'h0, {31'h0, gen});
      settle();
      chk("en global off", 32'h0, {29'h0, en});
      rchk(base[i], 8'hA0);
      host.wr(ADDR_GLOBAL_ENABLE, 8'h01);
      host.wr(base[i], 8'h20);
      settle();
      chk("en bit off", 32'h0, {29'h0, en});
      host.wr(base[i], 8'hA0);
      settle();
      chk("en bit on", 32'(1 << i), {29'h0, en});
      host.wr(base[i], 8'h20);
      host.wr(ADDR_GLOBAL_ENABLE, 8'h00);
    end
    $display("test enable done");
  endtask

  task automatic t_midreset();
    @(negedge clk);
    srst = 1'b1;
    repeat (2) @(negedge clk);
    srst = 1'b0;
    t_reset();
    $display("test mid-run reset done");
  endtask

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial
  begin
    #500000;
    n_mismatch++;
    finish_test();
  end

  initial
  begin
    srst = 1'b1;
    cg_ready = 1'b1;
    repeat (5) @(negedge clk);
    srst = 1'b0;
    t_reset();
    t_map();
    t_fields();
    t_enable();
    t_midreset();
    finish_test();
  end
endmodule // swr_regbank_tb_top

`default_nettype wire
